// File: ddp_regs.svh
`ifndef DDP_REGS_SVH
`define DDP_REGS_SVH
// i/o addresses of the channel 0 source address bytes
`define DDP_CH0_SRC_L_ADDR  8'hEE
`define DDP_CH0_SRC_H_ADDR  8'hEF
`define DDP_CH0_SRC_U_ADDR  8'hF0
// control register field positions
`define DDP_CTL_EN_BIT      0
`define DDP_CTL_BURST_BIT   1
`define DDP_CTL_IE_BIT      6
// reset values
`define DDP_CTL_RESET       8'h00
`define DDP_COUNT_TERMINAL  16'h0000
// cpu gap between stolen bytes, in clocks
`define DDP_STEAL_GAP       4'h8
`endif

// File: ddp_pkg.sv
package ddp_pkg;
  typedef enum logic [3:0] {
    DDP_IDLE = 4'b0001,
    DDP_XFER = 4'b0010,
    DDP_GAP  = 4'b0100,
    DDP_DONE = 4'b1000
  } ddp_state_t;
endpackage

// File: ddp_dual_dma.sv
// Overview of operation
// - channel 0 wins over channel 1 unless both steal
// - channel 0 burst finishes before channel 1
// - both steal: alternate bytes, 8 cpu clocks
// - alternation lasts until a channel finishes
// - ch0 steal, ch1 burst: ch1 waits
// - done interrupt only when control bit 6 set
// - interrupt enables cleared by reset
// - done when 16-bit count reaches 0000h
// - pending interrupt cleared by clearing enable bit
// - clearing interrupt enable keeps request asserted
// - cpu i/o reaches channel 0 source bytes
`timescale 1ns/1ps
`include "ddp_regs.svh"
module ddp_dual_dma
  import ddp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  ioAddr,
  input  wire logic [7:0]  ioWrData,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [7:0]  ch0CtlWr,
  input  wire logic        ch0CtlWrEn,
  input  wire logic [7:0]  ch1CtlWr,
  input  wire logic        ch1CtlWrEn,
  input  wire logic [15:0] ch0CountLoad,
  input  wire logic [15:0] ch1CountLoad,
  input  wire logic        busDone,
  output logic [7:0]       ioRdData,
  output logic [7:0]       ch0ControlReg,
  output logic [7:0]       ch1ControlReg,
  output logic [23:0]      ch0SrcAddr,
  output logic             busReq,
  output logic             busChan,
  output logic [1:0]       dmaIrq
);
  logic [7:0]  ctl_q [2];
  logic [15:0] count_q [2];
  logic [1:0]  irq_q;
  logic [23:0] src_q;
  logic [7:0]  rd_q;
  logic [3:0]  gap_q;
  logic        chan_q;
  logic        lastChan_q;
  ddp_state_t  state_q;
  logic [1:0]  en;
  logic [1:0]  burst;
  logic [1:0]  pick;
  logic        sel;
  logic [7:0]  ctlWr [2];
  logic        ctlWrEn [2];
  logic [15:0] countLoad [2];
  logic        load [2];
  logic        step [2];

  // per-channel views of the write ports so that one loop serves both channels
  assign ctlWr[0]     = ch0CtlWr;
  assign ctlWr[1]     = ch1CtlWr;
  assign ctlWrEn[0]   = ch0CtlWrEn;
  assign ctlWrEn[1]   = ch1CtlWrEn;
  assign countLoad[0] = ch0CountLoad;
  assign countLoad[1] = ch1CountLoad;

  // per-channel control, byte counter and completion interrupt
  for (genvar c = 0; c < 2; c++) begin : g_chan
    // only a rising enable reloads the count; rewriting an enabled channel keeps its progress
    assign load[c]  = ctlWrEn[c] && ctlWr[c][`DDP_CTL_EN_BIT] && !ctl_q[c][`DDP_CTL_EN_BIT];
    // one byte of this channel has just been moved by the system bus
    assign step[c]  = (state_q == DDP_XFER) && busDone && (chan_q == 1'(c));
    // a channel stops asking once its counter sits at the terminal value
    assign en[c]    = ctl_q[c][`DDP_CTL_EN_BIT] && (count_q[c] != `DDP_COUNT_TERMINAL);
    assign burst[c] = ctl_q[c][`DDP_CTL_BURST_BIT];

    // control register: reset clears enable and interrupt enable
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        ctl_q[c] <= `DDP_CTL_RESET;
      end else if (ctlWrEn[c]) begin
        ctl_q[c] <= ctlWr[c];
      end
    end

    // byte counter: loaded on enable, counts down once per byte moved
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        count_q[c] <= `DDP_COUNT_TERMINAL;
      end else if (load[c]) begin
        count_q[c] <= countLoad[c];
      end else if (step[c]) begin
        count_q[c] <= count_q[c] - 16'h0001;
      end
    end

    // sticky completion interrupt; the set wins over a clear in the same cycle
    // clearing only the interrupt enable leaves a raised request standing
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        irq_q[c] <= 1'b0;
      end else if (step[c] && count_q[c] == 16'h0001 && ctl_q[c][`DDP_CTL_IE_BIT]) begin
        irq_q[c] <= 1'b1;
      end else if (!ctl_q[c][`DDP_CTL_EN_BIT]) begin
        irq_q[c] <= 1'b0;
      end
    end
  end

  // arbitration: ch1 only when ch0 idle or both channels stealing and it is ch1's turn
  // a burst on either side means channel 0 runs to completion first
  always_comb begin
    pick = 2'b00;
    if (en[0] && !en[1]) begin
      pick = 2'b01;
    end else if (!en[0] && en[1]) begin
      pick = 2'b10;
    end else if (en[0] && en[1]) begin
      if (burst[0] || burst[1]) begin
        pick = 2'b01;
      end else begin
        pick = lastChan_q ? 2'b01 : 2'b10;
      end
    end
  end
  assign sel = pick[1];

  // transfer sequencer; steal mode always returns the bus for the gap
  // idle: grant to the picked channel; xfer: hold the bus until the byte or block ends
  // gap: the cpu owns the bus for the stolen-byte gap, then one idle cycle to re-arbitrate
  // limitation: a burst already under way is not cut short by a later channel 0 enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q    <= DDP_IDLE;
      gap_q      <= 4'h0;
      chan_q     <= 1'b0;
      lastChan_q <= 1'b1;
      busReq     <= 1'b0;
      busChan    <= 1'b0;
    end else begin
      case (state_q)
        DDP_IDLE: begin
          if (pick != 2'b00) begin
            state_q <= DDP_XFER;
            chan_q  <= sel;
            busReq  <= 1'b1;
            busChan <= sel;
          end
        end
        DDP_XFER: begin
          if (busDone) begin
            lastChan_q <= chan_q;
            if (!burst[chan_q]) begin
              busReq  <= 1'b0;
              state_q <= DDP_GAP;
              gap_q   <= `DDP_STEAL_GAP;
            end else if (count_q[chan_q] == 16'h0001) begin
              busReq  <= 1'b0;
              state_q <= DDP_DONE;
            end
          end
        end
        DDP_GAP: begin
          if (gap_q == 4'h1) state_q <= DDP_IDLE;
          gap_q <= gap_q - 4'h1;
        end
        DDP_DONE: state_q <= DDP_IDLE;
        default: state_q <= DDP_IDLE;
      endcase
    end
  end

  // channel 0 source address bytes, undefined until written
  // no reset on purpose: software must load all three bytes before use
  always_ff @(posedge core_clk) begin
    if (ioWr && ioAddr == `DDP_CH0_SRC_L_ADDR) begin
      src_q[7:0] <= ioWrData;
    end
    if (ioWr && ioAddr == `DDP_CH0_SRC_H_ADDR) begin
      src_q[15:8] <= ioWrData;
    end
    if (ioWr && ioAddr == `DDP_CH0_SRC_U_ADDR) begin
      src_q[23:16] <= ioWrData;
    end
  end

  // read port; unmapped addresses answer zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rd_q <= 8'h00;
    else if (ioRd) begin
      case (ioAddr)
        `DDP_CH0_SRC_L_ADDR: rd_q <= src_q[7:0];
        `DDP_CH0_SRC_H_ADDR: rd_q <= src_q[15:8];
        `DDP_CH0_SRC_U_ADDR: rd_q <= src_q[23:16];
        default: rd_q <= 8'h00;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dmaIrq        <= 2'b00;
      ch0ControlReg <= 8'h00;
      ch1ControlReg <= 8'h00;
      ch0SrcAddr    <= 24'h000000;
    end else begin
      dmaIrq        <= irq_q;
      ch0ControlReg <= ctl_q[0];
      ch1ControlReg <= ctl_q[1];
      ch0SrcAddr    <= src_q;
    end
  end
  assign ioRdData = rd_q;
endmodule

// File: ddp_bus_model.sv
`timescale 1ns/1ps
// system bus side: the first byte takes dly+1 clocks once the bus is granted, each later burst byte dly+2
module ddp_bus_model #(parameter logic [3:0] dly = 4'h2) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic busReq,
  output logic      busDone
);
  logic [3:0] cnt_q;
  // one-cycle done pulse; the count restarts so a burst is paced byte by byte
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      busDone <= 1'h0;
    end else begin
      busDone <= busReq && !busDone && cnt_q == dly;
      cnt_q <= (busReq && !busDone && cnt_q != dly) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

// File: ddp_monitor.sv
`timescale 1ns/1ps
module ddp_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        ioRd,
  input wire logic        busReq,
  input wire logic        busChan,
  input wire logic        busDone,
  input wire logic [7:0]  ioAddr,
  input wire logic [7:0]  ioRdData,
  input wire logic [7:0]  ch0ControlReg,
  input wire logic [7:0]  ch1ControlReg,
  input wire logic [23:0] ch0SrcAddr,
  input wire logic [1:0]  dmaIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // the cpu keeps the bus for the whole gap after a stolen byte
  sequence s_quiet; !busReq [*8]; endsequence
  property p_gap; $fell(busReq) && !ch0ControlReg[1] && !ch1ControlReg[1] |-> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("steal gap too short");
  property p_steal; busDone && busReq && !(busChan ? ch1ControlReg[1] : ch0ControlReg[1]) |=> !busReq; endproperty
  a_steal: assert property (p_steal) else $error("steal kept bus");
  property p_burst; busReq && !busChan && ch0ControlReg[1] && !busDone |=> busReq && !busChan; endproperty
  a_burst: assert property (p_burst) else $error("burst interrupted");
  // only clearing the enable may drop a raised request
  property p_hold; dmaIrq[0] && ch0ControlReg[0] && $past(ch0ControlReg[0]) |=> dmaIrq[0]; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_irq; $rose(dmaIrq[0]) |-> $past(ch0ControlReg[6], 2); endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_rdl; ioRd && ioAddr == 8'hEE |=> ioRdData == ch0SrcAddr[7:0]; endproperty
  a_rdl: assert property (p_rdl) else $error("low byte read");
  property p_rdu; ioRd && ioAddr == 8'hF0 |=> ioRdData == ch0SrcAddr[23:16]; endproperty
  a_rdu: assert property (p_rdu) else $error("upper byte read");
  property p_unm; ioRd && ioAddr == 8'h00 |=> ioRdData == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
endmodule
bind ddp_dual_dma ddp_monitor ddp_monitor_i (.*);

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic        core_clk = 0, reset = 1, ioWr = 0, ioRd = 0, ch0CtlWrEn = 0, ch1CtlWrEn = 0;
  logic        busDone, busReq, busChan;
  logic [7:0]  ioAddr = 0, ioWrData = 0, ch0CtlWr = 0, ch1CtlWr = 0, ioRdData, ch0ControlReg, ch1ControlReg;
  logic [15:0] ch0CountLoad = 16'h0002, ch1CountLoad = 16'h0003;
  logic [23:0] ch0SrcAddr;
  logic [1:0]  dmaIrq;
  int          failures = 0, n_tests = 0;
  always #5 core_clk = ~core_clk;
  ddp_dual_dma ddp_dual_dma_i (.*);
  ddp_bus_model #(.dly(4'h2)) ddp_bus_model_i (.*);
  task chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one i/o cycle; the strobe drops for two clocks so calls can follow back to back
  task io(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWr <= w;
    ioRd <= !w;
    @(posedge core_clk);
    ioWr <= 1'h0;
    ioRd <= 1'h0;
    @(posedge core_clk);
    #1 if (!w) chk(ioRdData, d);
  endtask
  task ctl(input logic c, input logic [7:0] v);
    @(posedge core_clk);
    ch0CtlWr <= v;
    ch1CtlWr <= v;
    ch0CtlWrEn <= !c;
    ch1CtlWrEn <= c;
    @(posedge core_clk);
    ch0CtlWrEn <= 1'h0;
    ch1CtlWrEn <= 1'h0;
  endtask
  // bounded wait for the requested interrupt lines
  task wt(input logic [1:0] m);
    for (int i = 0; i < 3000 && (dmaIrq & m) !== m; i++) begin
      @(posedge core_clk);
      #1;
    end
    if ((dmaIrq & m) !== m) begin
      failures++;
      $display("[FAIL] %0t irq wait ran out", $time);
      give_verdict;
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    #1 chk({6'h00, dmaIrq}, 8'h00);
    chk(ch0ControlReg, 8'h00);
    io(1, 8'hEE, 8'h5A);
    io(1, 8'hEF, 8'hA5);
    io(1, 8'hF0, 8'h3C);
    io(0, 8'hEE, 8'h5A);
    io(0, 8'hEF, 8'hA5);
    io(0, 8'hF0, 8'h3C);
    io(0, 8'h00, 8'h00);
    chk(ch0SrcAddr[23:16], 8'h3C);
    chk(ch0SrcAddr[7:0], 8'h5A);
    ctl(0, 8'h41);
    ctl(1, 8'h41);
    @(posedge core_clk);
    #1 chk(ch1ControlReg, 8'h41);
    wt(2'h3);
    ctl(0, 8'h01);
    repeat (4) @(posedge core_clk);
    #1 chk({6'h00, dmaIrq}, 8'h03);
    ctl(0, 8'h00);
    ctl(1, 8'h00);
    repeat (4) @(posedge core_clk);
    #1 chk({6'h00, dmaIrq}, 8'h00);
    ctl(0, 8'h03);
    ctl(1, 8'h41);
    wt(2'h2);
    #1 chk({6'h00, dmaIrq}, 8'h02);
    give_verdict;
  end
endmodule
